/* File: pfm_pkg.sv */
package pfm_pkg;

  // Pin counts per group and their place in the combined pin vector
  localparam int W3 = 10;
  localparam int W4 = 3;
  localparam int W5 = 6;
  localparam int WALL = 19;
  localparam int B4 = 10;
  localparam int B5 = 13;
  localparam int GRP_CNT = 3;

  // Implemented bits per group (group 3 has no pins 6 and 7)
  localparam logic [15:0] GRP_MASK [0:2] = '{16'h033f, 16'h0007, 16'h003f};

  // Register map: group g at g * 0x20, 16-bit data in the low bits
  localparam logic [4:0] OFS_PDATA = 5'h00;
  localparam logic [4:0] OFS_PDIR = 5'h04;
  localparam logic [4:0] OFS_MODE = 5'h08;
  localparam logic [4:0] OFS_SEL_LO = 5'h0c;
  localparam logic [4:0] OFS_SEL_HI = 5'h10;
  localparam logic [4:0] OFS_LEVEL = 5'h14;
  localparam logic [7:0] OFS_DEBUG = 8'h60;
  localparam int GRP_LSB = 5;

  // Reset values
  localparam logic [15:0] RST_PDIR = 16'hffff;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic RST_DEBUG = 1'b1;

  // Level seen by a peripheral input that is not routed to a pin
  localparam logic INACT = 1'b0;

  // Function select codes, written {select_high, select_low}
  localparam logic [1:0] SEL_00 = 2'h0;
  localparam logic [1:0] SEL_LO = 2'h1;
  localparam logic [1:0] SEL_HI = 2'h2;
  localparam logic [1:0] SEL_BOTH = 2'h3;

  typedef struct packed {
    logic [15:0] pdata;
    logic [15:0] pdir;
    logic [15:0] mode;
    logic [15:0] sel_lo;
    logic [15:0] sel_hi;
  } pfm_grp_type;

  typedef struct packed {
    logic serial0_receive;
    logic ext_interrupt_7;
    logic serial0_clock_in;
    logic capture_in_p00;
    logic capture_in_p01;
    logic capture_in_p10;
    logic capture_in_p11;
    logic serial2_receive;
    logic ext_interrupt_8;
    logic clocked_serial_data_in;
    logic clocked_serial_clock_in;
    logic [5:0] key_return_in;
    logic [3:0] capture_in_q0;
    logic debug_data_in;
  } pfm_route_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } pfm_bus_type;

endpackage

/* File: pfm_pin_sync.sv */
`timescale 1ns/1ps
module pfm_pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] lvl
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] lvl_ff;
  logic [W-1:0] nxt_lvl;

  // A change counts once the second and third stages agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      lvl_ff <= '0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign lvl = lvl_ff;

endmodule // pfm_pin_sync

/* File: pfm_pin_drive.sv */
`timescale 1ns/1ps
module pfm_pin_drive #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] mode,
  input wire logic [W-1:0] pdata,
  input wire logic [W-1:0] pdir,
  input wire logic [W-1:0] fout,
  input wire logic [W-1:0] foe,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe
);

  logic [W-1:0] out_ff;
  logic [W-1:0] oe_ff;
  logic [W-1:0] nxt_out;
  logic [W-1:0] nxt_oe;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      always_comb begin
        if (mode[i]) begin
          nxt_out[i] = fout[i];
          nxt_oe[i] = foe[i];
        end else begin
          nxt_out[i] = pdata[i];
          nxt_oe[i] = ~pdir[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_ff <= '0;
      oe_ff <= '0;
    end else begin
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
    end
  end

  assign pin_out = out_ff;
  assign pin_oe = oe_ff;

  a_func_owns_pin:
  assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> ((pin_out ^ $past(fout)) & $past(mode)) == '0
      && ((pin_oe ^ $past(foe)) & $past(mode)) == '0)
  else $error("function pin does not follow its peripheral");

  a_port_owns_pin:
  assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> ((pin_out ^ $past(pdata)) & ~$past(mode)) == '0
      && ((pin_oe ^ ~$past(pdir)) & ~$past(mode)) == '0)
  else $error("port pin does not follow data and direction");

endmodule // pfm_pin_drive

/* File: pfm_mux_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Mode bit 1 gives the pin to its peripheral; port data is ignored.
// - Group 3 pin 2: clock in, compare p01, capture p00, compare p00.
// - Group 3 pins 3-5: select 0 capture input, 1 compare output.
// - Single-function pins carry their one signal when mode bit set.
// - Group 5 pins 0-3: low select key/capture in, high select compare.
// - Group 5 pins 4-5: mode and low select give key-return input.
// - Debug bit forces group 5 pins 2-5 onto the debug lines.
// - Debug bit is set by reset; clearing it frees the pins.
module pfm_mux_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [9:0] P3_PIN_IN,
  output logic [9:0] P3_PIN_OUT,
  output logic [9:0] P3_PIN_OE,
  input wire logic [2:0] P4_PIN_IN,
  output logic [2:0] P4_PIN_OUT,
  output logic [2:0] P4_PIN_OE,
  input wire logic [5:0] P5_PIN_IN,
  output logic [5:0] P5_PIN_OUT,
  output logic [5:0] P5_PIN_OE,
  input wire logic SERIAL0_TRANSMIT,
  input wire logic SERIAL2_TRANSMIT,
  input wire logic COMPARE_OUT_P00,
  input wire logic COMPARE_OUT_P01,
  input wire logic COMPARE_OUT_P10,
  input wire logic COMPARE_OUT_P11,
  input wire logic [3:0] COMPARE_OUT_Q0,
  input wire logic CLOCKED_SERIAL_DATA_OUT,
  input wire logic CLOCKED_SERIAL_CLOCK_OUT,
  input wire logic CLOCKED_SERIAL_CLOCK_OE,
  input wire logic DEBUG_DATA_OUT,
  input wire logic DEBUG_CLOCK,
  input wire logic DEBUG_MODE_SELECT,
  output logic SERIAL0_RECEIVE,
  output logic EXT_INTERRUPT_7,
  output logic SERIAL0_CLOCK_IN,
  output logic CAPTURE_IN_P00,
  output logic CAPTURE_IN_P01,
  output logic CAPTURE_IN_P10,
  output logic CAPTURE_IN_P11,
  output logic SERIAL2_RECEIVE,
  output logic EXT_INTERRUPT_8,
  output logic CLOCKED_SERIAL_DATA_IN,
  output logic CLOCKED_SERIAL_CLOCK_IN,
  output logic [5:0] KEY_RETURN_IN,
  output logic [3:0] CAPTURE_IN_Q0,
  output logic DEBUG_DATA_IN,
  output logic DEBUG_PIN_MODE
);

  pfm_pkg::pfm_grp_type cfg_ff [0:2];
  pfm_pkg::pfm_grp_type nxt_cfg [0:2];
  logic dbg_ff;
  logic nxt_dbg;
  pfm_pkg::pfm_bus_type bus_ff;
  pfm_pkg::pfm_bus_type nxt_bus;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  pfm_pkg::pfm_route_type route_ff;
  pfm_pkg::pfm_route_type nxt_route;
  logic [pfm_pkg::WALL-1:0] lvl;
  logic [pfm_pkg::WALL-1:0] mode_all;
  logic [pfm_pkg::WALL-1:0] eff_mode;
  logic [pfm_pkg::WALL-1:0] pdata_all;
  logic [pfm_pkg::WALL-1:0] pdir_all;
  logic [pfm_pkg::WALL-1:0] fout;
  logic [pfm_pkg::WALL-1:0] foe;
  logic [pfm_pkg::WALL-1:0] pin_out;
  logic [pfm_pkg::WALL-1:0] pin_oe;
  logic [1:0] sel3_2;

  function automatic logic [15:0] wr16(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] be, input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (be[0]) v[7:0] = d[7:0];
    if (be[1]) v[15:8] = d[15:8];
    return v & m;
  endfunction

  function automatic logic [1:0] sel5(input int n,
      input pfm_pkg::pfm_grp_type g);
    return {g.sel_hi[n], g.sel_lo[n]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Wishbone register slave

  always_comb begin
    logic hit;
    logic [1:0] grp;
    logic [4:0] ofs;
    hit = WB_CYC_I && WB_STB_I && (bus_ff == pfm_pkg::BUS_IDLE);
    grp = WB_ADR_I[pfm_pkg::GRP_LSB +: 2];
    ofs = WB_ADR_I[4:0];
    nxt_cfg = cfg_ff;
    nxt_dbg = dbg_ff;
    nxt_dat = 32'h0000_0000;
    case (bus_ff)
      pfm_pkg::BUS_IDLE: nxt_bus = hit ? pfm_pkg::BUS_ACK : pfm_pkg::BUS_IDLE;
      pfm_pkg::BUS_ACK: nxt_bus = pfm_pkg::BUS_IDLE;
      default: nxt_bus = pfm_pkg::BUS_IDLE;
    endcase
    if (hit && WB_ADR_I == pfm_pkg::OFS_DEBUG) begin
      if (WB_WE_I && WB_SEL_I[0]) begin
        nxt_dbg = WB_DAT_I[0];
      end
      nxt_dat = {31'h0000_0000, dbg_ff};
    end else if (hit && !WB_ADR_I[7] && grp < 2'(pfm_pkg::GRP_CNT)) begin
      case (ofs)
        pfm_pkg::OFS_PDATA: begin
          if (WB_WE_I) begin
            nxt_cfg[grp].pdata = wr16(cfg_ff[grp].pdata, WB_DAT_I,
                WB_SEL_I, pfm_pkg::GRP_MASK[grp]);
          end
          nxt_dat = {16'h0000, cfg_ff[grp].pdata};
        end
        pfm_pkg::OFS_PDIR: begin
          if (WB_WE_I) begin
            nxt_cfg[grp].pdir = wr16(cfg_ff[grp].pdir, WB_DAT_I,
                WB_SEL_I, pfm_pkg::GRP_MASK[grp]);
          end
          nxt_dat = {16'h0000, cfg_ff[grp].pdir};
        end
        pfm_pkg::OFS_MODE: begin
          if (WB_WE_I) begin
            nxt_cfg[grp].mode = wr16(cfg_ff[grp].mode, WB_DAT_I,
                WB_SEL_I, pfm_pkg::GRP_MASK[grp]);
          end
          nxt_dat = {16'h0000, cfg_ff[grp].mode};
        end
        pfm_pkg::OFS_SEL_LO: begin
          if (WB_WE_I) begin
            nxt_cfg[grp].sel_lo = wr16(cfg_ff[grp].sel_lo, WB_DAT_I,
                WB_SEL_I, pfm_pkg::GRP_MASK[grp]);
          end
          nxt_dat = {16'h0000, cfg_ff[grp].sel_lo};
        end
        pfm_pkg::OFS_SEL_HI: begin
          if (WB_WE_I) begin
            nxt_cfg[grp].sel_hi = wr16(cfg_ff[grp].sel_hi, WB_DAT_I,
                WB_SEL_I, pfm_pkg::GRP_MASK[grp]);
          end
          nxt_dat = {16'h0000, cfg_ff[grp].sel_hi};
        end
        pfm_pkg::OFS_LEVEL: begin
          case (grp)
            2'h0: nxt_dat = 32'(lvl[pfm_pkg::W3-1:0]
                & pfm_pkg::GRP_MASK[0][pfm_pkg::W3-1:0]);
            2'h1: nxt_dat = 32'(lvl[pfm_pkg::B4 +: pfm_pkg::W4]);
            default: nxt_dat = 32'(lvl[pfm_pkg::B5 +: pfm_pkg::W5]);
          endcase
        end
        default: nxt_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int g = 0; g < pfm_pkg::GRP_CNT; g++) begin
        cfg_ff[g].pdata <= pfm_pkg::RST_ZERO;
        cfg_ff[g].pdir <= pfm_pkg::RST_PDIR & pfm_pkg::GRP_MASK[g];
        cfg_ff[g].mode <= pfm_pkg::RST_ZERO;
        cfg_ff[g].sel_lo <= pfm_pkg::RST_ZERO;
        cfg_ff[g].sel_hi <= pfm_pkg::RST_ZERO;
      end
      dbg_ff <= pfm_pkg::RST_DEBUG;
      bus_ff <= pfm_pkg::BUS_IDLE;
      dat_ff <= 32'h0000_0000;
    end else begin
      cfg_ff <= nxt_cfg;
      dbg_ff <= nxt_dbg;
      bus_ff <= nxt_bus;
      dat_ff <= nxt_dat;
    end
  end

  assign WB_ACK_O = (bus_ff == pfm_pkg::BUS_ACK);
  assign WB_DAT_O = dat_ff;
  assign DEBUG_PIN_MODE = dbg_ff;

  ////////////////////////////////////////////////////////////////////////
  // Pin side: synchronise, select functions, drive

  pfm_pin_sync #(.W(pfm_pkg::WALL)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .pin({P5_PIN_IN, P4_PIN_IN, P3_PIN_IN}),
    .lvl(lvl)
  );

  assign mode_all = {cfg_ff[2].mode[pfm_pkg::W5-1:0],
      cfg_ff[1].mode[pfm_pkg::W4-1:0], cfg_ff[0].mode[pfm_pkg::W3-1:0]};
  assign pdata_all = {cfg_ff[2].pdata[pfm_pkg::W5-1:0],
      cfg_ff[1].pdata[pfm_pkg::W4-1:0], cfg_ff[0].pdata[pfm_pkg::W3-1:0]};
  // Pins 6 and 7 of group 3 do not exist: keep them as inputs
  assign pdir_all = {cfg_ff[2].pdir[pfm_pkg::W5-1:0],
      cfg_ff[1].pdir[pfm_pkg::W4-1:0],
      cfg_ff[0].pdir[pfm_pkg::W3-1:0]
      | ~pfm_pkg::GRP_MASK[0][pfm_pkg::W3-1:0]};
  assign sel3_2 = {cfg_ff[0].sel_hi[2], cfg_ff[0].sel_lo[2]};

  always_comb begin
    fout = '0;
    foe = '0;
    eff_mode = mode_all;
    fout[0] = SERIAL0_TRANSMIT;
    foe[0] = 1'b1;
    fout[8] = SERIAL2_TRANSMIT;
    foe[8] = 1'b1;
    fout[pfm_pkg::B4 + 1] = CLOCKED_SERIAL_DATA_OUT;
    foe[pfm_pkg::B4 + 1] = 1'b1;
    fout[pfm_pkg::B4 + 2] = CLOCKED_SERIAL_CLOCK_OUT;
    foe[pfm_pkg::B4 + 2] = CLOCKED_SERIAL_CLOCK_OE;
    case (sel3_2)
      pfm_pkg::SEL_LO: begin
        fout[2] = COMPARE_OUT_P01;
        foe[2] = 1'b1;
      end
      pfm_pkg::SEL_BOTH: begin
        fout[2] = COMPARE_OUT_P00;
        foe[2] = 1'b1;
      end
      default: foe[2] = 1'b0;
    endcase
    fout[3] = COMPARE_OUT_P01;
    foe[3] = cfg_ff[0].sel_lo[3];
    fout[4] = COMPARE_OUT_P10;
    foe[4] = cfg_ff[0].sel_lo[4];
    fout[5] = COMPARE_OUT_P11;
    foe[5] = cfg_ff[0].sel_lo[5];
    // compare output on high select only
    for (int n = 0; n < 4; n++) begin
      fout[pfm_pkg::B5 + n] = COMPARE_OUT_Q0[2'(n + 1)];
      // other codes leave the pin undriven
      foe[pfm_pkg::B5 + n] = (sel5(n, cfg_ff[2]) == pfm_pkg::SEL_HI);
    end
    if (dbg_ff) begin
      // debug lines override port and select bits
      eff_mode[pfm_pkg::B5 + 5 : pfm_pkg::B5 + 2] = 4'hf;
      foe[pfm_pkg::B5 + 2] = 1'b0;
      fout[pfm_pkg::B5 + 3] = DEBUG_DATA_OUT;
      foe[pfm_pkg::B5 + 3] = 1'b1;
      fout[pfm_pkg::B5 + 4] = DEBUG_CLOCK;
      foe[pfm_pkg::B5 + 4] = 1'b1;
      fout[pfm_pkg::B5 + 5] = DEBUG_MODE_SELECT;
      foe[pfm_pkg::B5 + 5] = 1'b1;
    end
  end

  pfm_pin_drive #(.W(pfm_pkg::WALL)) u_drive (
    .clk(CLK),
    .rst_n(RST_N),
    .mode(eff_mode),
    .pdata(pdata_all),
    .pdir(pdir_all),
    .fout(fout),
    .foe(foe),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  assign P3_PIN_OUT = pin_out[pfm_pkg::W3-1:0];
  assign P3_PIN_OE = pin_oe[pfm_pkg::W3-1:0];
  assign P4_PIN_OUT = pin_out[pfm_pkg::B4 +: pfm_pkg::W4];
  assign P4_PIN_OE = pin_oe[pfm_pkg::B4 +: pfm_pkg::W4];
  assign P5_PIN_OUT = pin_out[pfm_pkg::B5 +: pfm_pkg::W5];
  assign P5_PIN_OE = pin_oe[pfm_pkg::B5 +: pfm_pkg::W5];

  ////////////////////////////////////////////////////////////////////////
  // Peripheral inputs routed from pins

  always_comb begin
    logic on;
    on = 1'b0;
    nxt_route = '0;
    // both functions see the shared pin; software picks one
    nxt_route.serial0_receive = mode_all[1] ? lvl[1] : pfm_pkg::INACT;
    nxt_route.ext_interrupt_7 = mode_all[1] ? lvl[1] : pfm_pkg::INACT;
    nxt_route.serial2_receive = mode_all[9] ? lvl[9] : pfm_pkg::INACT;
    nxt_route.ext_interrupt_8 = mode_all[9] ? lvl[9] : pfm_pkg::INACT;
    nxt_route.serial0_clock_in = (mode_all[2] && sel3_2 == pfm_pkg::SEL_00)
        ? lvl[2] : pfm_pkg::INACT;
    nxt_route.capture_in_p00 = (mode_all[2] && sel3_2 == pfm_pkg::SEL_HI)
        ? lvl[2] : pfm_pkg::INACT;
    nxt_route.capture_in_p01 = (mode_all[3] && !cfg_ff[0].sel_lo[3])
        ? lvl[3] : pfm_pkg::INACT;
    nxt_route.capture_in_p10 = (mode_all[4] && !cfg_ff[0].sel_lo[4])
        ? lvl[4] : pfm_pkg::INACT;
    nxt_route.capture_in_p11 = (mode_all[5] && !cfg_ff[0].sel_lo[5])
        ? lvl[5] : pfm_pkg::INACT;
    nxt_route.clocked_serial_data_in = mode_all[pfm_pkg::B4]
        ? lvl[pfm_pkg::B4] : pfm_pkg::INACT;
    nxt_route.clocked_serial_clock_in = mode_all[pfm_pkg::B4 + 2]
        ? lvl[pfm_pkg::B4 + 2] : pfm_pkg::INACT;
    for (int n = 0; n < 6; n++) begin
      on = mode_all[pfm_pkg::B5 + n] && !(dbg_ff && n >= 2);
      if (n < 4) begin
        // key-return and capture share one code
        on = on && sel5(n, cfg_ff[2]) == pfm_pkg::SEL_LO;
        nxt_route.capture_in_q0[2'(n + 1)] = on ? lvl[pfm_pkg::B5 + n]
            : pfm_pkg::INACT;
      end else begin
        on = on && cfg_ff[2].sel_lo[n];
      end
      nxt_route.key_return_in[n] = on ? lvl[pfm_pkg::B5 + n]
          : pfm_pkg::INACT;
    end
    nxt_route.debug_data_in = dbg_ff ? lvl[pfm_pkg::B5 + 2] : pfm_pkg::INACT;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      route_ff <= '0;
    end else begin
      route_ff <= nxt_route;
    end
  end

  assign SERIAL0_RECEIVE = route_ff.serial0_receive;
  assign EXT_INTERRUPT_7 = route_ff.ext_interrupt_7;
  assign SERIAL0_CLOCK_IN = route_ff.serial0_clock_in;
  assign CAPTURE_IN_P00 = route_ff.capture_in_p00;
  assign CAPTURE_IN_P01 = route_ff.capture_in_p01;
  assign CAPTURE_IN_P10 = route_ff.capture_in_p10;
  assign CAPTURE_IN_P11 = route_ff.capture_in_p11;
  assign SERIAL2_RECEIVE = route_ff.serial2_receive;
  assign EXT_INTERRUPT_8 = route_ff.ext_interrupt_8;
  assign CLOCKED_SERIAL_DATA_IN = route_ff.clocked_serial_data_in;
  assign CLOCKED_SERIAL_CLOCK_IN = route_ff.clocked_serial_clock_in;
  assign KEY_RETURN_IN = route_ff.key_return_in;
  assign CAPTURE_IN_Q0 = route_ff.capture_in_q0;
  assign DEBUG_DATA_IN = route_ff.debug_data_in;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_tx0_route:
  assert property (@(posedge CLK) disable iff (!RST_N)
    $past(mode_all[0]) |-> P3_PIN_OE[0]
      && P3_PIN_OUT[0] == $past(SERIAL0_TRANSMIT))
  else $error("transmit pin not driven by serial unit");

  a_ck0_select:
  assert property (@(posedge CLK) disable iff (!RST_N)
    $past(mode_all[2] && sel3_2 == 2'h0) |-> !P3_PIN_OE[2]
      && SERIAL0_CLOCK_IN == $past(lvl[2]))
  else $error("serial clock input not selected");

  a_cmp_p00_out:
  assert property (@(posedge CLK) disable iff (!RST_N)
    $past(mode_all[2] && sel3_2 == 2'h3) |-> P3_PIN_OE[2]
      && P3_PIN_OUT[2] == $past(COMPARE_OUT_P00))
  else $error("compare p00 not on pin 2");

  a_cap_p10_in:
  assert property (@(posedge CLK) disable iff (!RST_N)
    $past(mode_all[4] && !cfg_ff[0].sel_lo[4]) |-> !P3_PIN_OE[4]
      && CAPTURE_IN_P10 == $past(lvl[4]))
  else $error("capture p10 not routed");

  a_kr_capture:
  assert property (@(posedge CLK) disable iff (!RST_N)
    $past(mode_all[13] && sel5(0, cfg_ff[2]) == 2'h1) |->
      KEY_RETURN_IN[0] == $past(lvl[13])
      && CAPTURE_IN_Q0[1] == $past(lvl[13]))
  else $error("key return or capture q01 not routed");

  a_kr_pin4:
  assert property (@(posedge CLK) disable iff (!RST_N)
    $past(!dbg_ff && mode_all[17] && cfg_ff[2].sel_lo[4]) |->
      KEY_RETURN_IN[4] == $past(lvl[17]))
  else $error("key return 4 not routed");

  a_dbg_override:
  assert property (@(posedge CLK) disable iff (!RST_N)
    $past(RST_N && dbg_ff) |-> P5_PIN_OE[3]
      && P5_PIN_OUT[3] == $past(DEBUG_DATA_OUT)
      && KEY_RETURN_IN[2] == 1'b0 && !P5_PIN_OE[2])
  else $error("debug lines do not own group 5 pins");

  a_dbg_reset:
  assert property (@(posedge CLK) disable iff (!RST_N)
    $past(!RST_N) |-> dbg_ff && P5_PIN_OE == 6'h00)
  else $error("debug mode not set after reset");

  a_unrouted_idle:
  assert property (@(posedge CLK) disable iff (!RST_N)
    !$past(mode_all[2]) |-> SERIAL0_CLOCK_IN == 1'b0
      && CAPTURE_IN_P00 == 1'b0)
  else $error("unrouted input not inactive");

endmodule // pfm_mux_top

/* File: pfm_periph_model.sv */
`timescale 1ns/1ps
module pfm_periph_model (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [15:0] LVL,
  output logic SERIAL0_TRANSMIT,
  output logic SERIAL2_TRANSMIT,
  output logic COMPARE_OUT_P00,
  output logic COMPARE_OUT_P01,
  output logic COMPARE_OUT_P10,
  output logic COMPARE_OUT_P11,
  output logic [3:0] COMPARE_OUT_Q0,
  output logic CLOCKED_SERIAL_DATA_OUT,
  output logic CLOCKED_SERIAL_CLOCK_OUT,
  output logic CLOCKED_SERIAL_CLOCK_OE,
  output logic DEBUG_DATA_OUT,
  output logic DEBUG_CLOCK,
  output logic DEBUG_MODE_SELECT
);
  logic [15:0] lvl_ff;
  logic [15:0] nxt_lvl;
  // Levels move only just after an edge, like a peripheral's flops
  always_comb begin
    nxt_lvl = LVL;
    if (!RST_N) begin
      nxt_lvl = 16'h0000;
    end
  end
  always_ff @(posedge CLK) begin
    lvl_ff <= nxt_lvl;
  end
  assign {SERIAL0_TRANSMIT, SERIAL2_TRANSMIT, COMPARE_OUT_P00,
    COMPARE_OUT_P01, COMPARE_OUT_P10, COMPARE_OUT_P11, COMPARE_OUT_Q0,
    CLOCKED_SERIAL_DATA_OUT, CLOCKED_SERIAL_CLOCK_OUT,
    CLOCKED_SERIAL_CLOCK_OE, DEBUG_DATA_OUT, DEBUG_CLOCK,
    DEBUG_MODE_SELECT} = lvl_ff;
endmodule // pfm_periph_model

/* File: pfm_mux_top_bench.sv */
`timescale 1ns/1ps
module pfm_mux_top_bench;
  typedef struct packed {
    logic [3:0] g;
    logic [3:0] pin;
    logic [3:0] code;
    logic [15:0] per;
    logic [3:0] oe;
    logic [3:0] out;
    logic [23:0] rt;
  } pfm_row_type;
  localparam int SETTLE = 8;
  logic CLK = 1'b0, RST_N = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0;
  logic WB_WE_I = 1'b0, WB_ACK_O;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [3:0] WB_SEL_I = 4'h3;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O;
  logic [9:0] P3_PIN_IN = 10'h3ff, P3_PIN_OUT, P3_PIN_OE;
  logic [2:0] P4_PIN_IN = 3'h7, P4_PIN_OUT, P4_PIN_OE;
  logic [5:0] P5_PIN_IN = 6'h3f, P5_PIN_OUT, P5_PIN_OE;
  logic [15:0] LVL = 16'h0000;
  logic SERIAL0_TRANSMIT, SERIAL2_TRANSMIT, COMPARE_OUT_P00;
  logic COMPARE_OUT_P01, COMPARE_OUT_P10, COMPARE_OUT_P11;
  logic CLOCKED_SERIAL_DATA_OUT, CLOCKED_SERIAL_CLOCK_OUT;
  logic CLOCKED_SERIAL_CLOCK_OE, DEBUG_DATA_OUT, DEBUG_CLOCK;
  logic DEBUG_MODE_SELECT, SERIAL0_RECEIVE, EXT_INTERRUPT_7;
  logic SERIAL0_CLOCK_IN, CAPTURE_IN_P00, CAPTURE_IN_P01, CAPTURE_IN_P10;
  logic CAPTURE_IN_P11, SERIAL2_RECEIVE, EXT_INTERRUPT_8, DEBUG_DATA_IN;
  logic CLOCKED_SERIAL_DATA_IN, CLOCKED_SERIAL_CLOCK_IN, DEBUG_PIN_MODE;
  logic [3:0] COMPARE_OUT_Q0, CAPTURE_IN_Q0;
  logic [5:0] KEY_RETURN_IN;
  pfm_pkg::pfm_route_type rt;
  logic [18:0] pout, poe;
  int num_errors = 0, checks_done = 0;
  // Rows: group, pin, {high, low} select, peripheral levels, oe, out, route
  pfm_row_type rows [0:24] = '{
    60'h0_0_0_8000_1_1_000000, 60'h0_1_0_0000_0_0_300000,
    60'h0_2_0_0000_0_0_080000, 60'h0_2_1_1000_1_1_000000,
    60'h0_2_2_0000_0_0_040000, 60'h0_2_3_2000_1_1_000000,
    60'h0_3_0_0000_0_0_020000, 60'h0_3_1_1000_1_1_000000,
    60'h0_4_0_0000_0_0_010000, 60'h0_5_1_0400_1_1_000000,
    60'h0_8_0_4000_1_1_000000, 60'h0_9_0_0000_0_0_006000,
    60'h1_0_0_0000_0_0_001000, 60'h1_1_0_0020_1_1_000000,
    60'h1_2_0_0010_0_0_000800, 60'h2_0_1_0000_0_0_000024,
    60'h2_0_2_0080_1_1_000000, 60'h2_1_1_0000_0_0_000048,
    60'h2_1_0_0000_0_0_000000, 60'h2_2_3_0000_0_0_000000,
    60'h2_2_2_0200_1_1_000000, 60'h2_3_1_0000_0_0_000102,
    60'h2_3_2_0040_1_1_000000, 60'h2_4_1_0000_0_0_000200,
    60'h2_5_1_0000_0_0_000400};
  assign rt = {SERIAL0_RECEIVE, EXT_INTERRUPT_7, SERIAL0_CLOCK_IN,
    CAPTURE_IN_P00, CAPTURE_IN_P01, CAPTURE_IN_P10, CAPTURE_IN_P11,
    SERIAL2_RECEIVE, EXT_INTERRUPT_8, CLOCKED_SERIAL_DATA_IN,
    CLOCKED_SERIAL_CLOCK_IN, KEY_RETURN_IN, CAPTURE_IN_Q0, DEBUG_DATA_IN};
  assign pout = {P5_PIN_OUT, P4_PIN_OUT, P3_PIN_OUT};
  assign poe = {P5_PIN_OE, P4_PIN_OE, P3_PIN_OE};
  always #4 CLK = ~CLK;
  pfm_mux_top uut (.*);
  pfm_periph_model peri (.*);
  ////////////////////////////////////////////////////////////////
  task automatic note(input string s, input logic [31:0] e,
      input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_reg(input string s, input logic [15:0] e,
      input logic [15:0] g);
    note(s, {16'h0000, e}, {16'h0000, g});
  endtask
  task automatic chk_pin(input string s, input logic e, input logic g);
    note(s, {31'h0, e}, {31'h0, g});
  endtask
  task automatic chk_route(input pfm_pkg::pfm_route_type e);
    note("route", {10'h0, e}, {10'h0, rt});
  endtask
  task automatic bus(input logic [7:0] a, input logic we,
      input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= {16'h0000, d};
    do begin
      @(posedge CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 16);
    q = WB_DAT_O[15:0];
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    if (n >= 16) note("ack", 32'h1, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    bus(a, 1'b0, 16'h0000, q);
    chk_reg($sformatf("reg %h", a), e, q);
  endtask
  task automatic settle();
    repeat (SETTLE) @(posedge CLK);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    pfm_row_type r;
    int b;
    logic [7:0] base;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    LVL <= 16'h0007;
    settle();
    rd(8'h04, 16'h033f);
    rd(8'h24, 16'h0007);
    rd(8'h44, 16'h003f);
    rd(8'h60, 16'h0001);
    chk_pin("debug_mode", 1'b1, DEBUG_PIN_MODE);
    chk_reg("p5_oe", 16'h0038, {10'h0, P5_PIN_OE});
    chk_reg("p3_oe", 16'h0000, {6'h0, P3_PIN_OE});
    chk_reg("p5_out", 16'h0007, {13'h0, P5_PIN_OUT[5:3]});
    chk_route(22'h000001);
    wr(8'h4c, 16'h0008);
    wr(8'h48, 16'h0008);
    LVL <= 16'h0041;
    settle();
    chk_reg("p5_out", 16'h0004, {13'h0, P5_PIN_OUT[5:3]});
    chk_route(22'h000001);
    wr(8'h48, 16'h0000);
    wr(8'h4c, 16'h0000);
    wr(8'h60, 16'h0000);
    settle();
    chk_pin("debug_mode", 1'b0, DEBUG_PIN_MODE);
    chk_reg("p5_oe", 16'h0000, {10'h0, P5_PIN_OE});
    wr(8'h7c, 16'hffff);
    rd(8'h7c, 16'h0000);
    wr(8'h14, 16'h0000);
    rd(8'h14, 16'h033f);
    // port control, then peripheral takes over
    wr(8'h04, 16'h033e);
    wr(8'h00, 16'h0001);
    settle();
    chk_pin("p3_oe0", 1'b1, P3_PIN_OE[0]);
    chk_pin("p3_out0", 1'b1, P3_PIN_OUT[0]);
    LVL <= 16'h0000;
    wr(8'h08, 16'h0001);
    settle();
    chk_pin("p3_out0", 1'b0, P3_PIN_OUT[0]);
    wr(8'h08, 16'h0000);
    wr(8'h04, 16'h033f);
    // each row: select a pin function, check pin drive and routed inputs
    foreach (rows[i]) begin
      r = rows[i];
      base = {r.g[2:0], 5'h00};
      b = r.pin + (r.g == 1 ? pfm_pkg::B4 : r.g == 2 ? pfm_pkg::B5 : 0);
      LVL <= r.per;
      {P5_PIN_IN, P4_PIN_IN, P3_PIN_IN} <= 19'h7ffff;
      wr(base + 8'h0c, {15'h0, r.code[0]} << r.pin);
      wr(base + 8'h10, {15'h0, r.code[1]} << r.pin);
      wr(base + 8'h08, 16'h0001 << r.pin);
      settle();
      chk_pin("oe", r.oe[0], poe[b]);
      if (r.oe[0]) chk_pin("out", r.out[0], pout[b]);
      chk_route(r.rt[21:0]);
      LVL <= ~r.per;
      {P5_PIN_IN, P4_PIN_IN, P3_PIN_IN} <= 19'h00000;
      settle();
      if (r.oe[0]) chk_pin("out", ~r.out[0], pout[b]);
      chk_route(22'h000000);
      wr(base + 8'h08, 16'h0000);
    end
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    settle();
    chk_pin("debug_mode", 1'b1, DEBUG_PIN_MODE);
    rd(8'h60, 16'h0001);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    $display("[FAIL] watchdog expected done seen timeout");
    test_done();
  end
endmodule // pfm_mux_top_bench
